// ---- core/hpp_pkg.sv ----
/*
  Shared definitions for the hub port power and strap control block:
  register offsets, reset values, field positions and carrier types.
  Assumes one 125 MHz clock and a synchronous active-high reset.
*/
package hpp_pkg;

  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned NUM_CTL_PINS = 2;

  // Register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STRAP = 8'h04;
  localparam logic [7:0] REG_PORT_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_CLR = 8'h10;
  localparam logic [7:0] REG_IRQ_EN = 8'h14;
  localparam logic [7:0] REG_GPIO = 8'h18;

  // Control register fields
  localparam int unsigned CTRL_PWR_REQ_LSB = 0;
  localparam int unsigned CTRL_GPIO_MODE_BIT = 4;
  localparam int unsigned CTRL_OC_CLR_LSB = 8;

  // Gpio register fields
  localparam int unsigned GPIO_OUT_BIT = 0;
  localparam int unsigned GPIO_OE_BIT = 1;
  localparam int unsigned GPIO_IN_BIT = 2;

  // Strap register fields
  localparam int unsigned STRAP_PLUS_LSB = 0;
  localparam int unsigned STRAP_MINUS_LSB = 4;
  localparam int unsigned STRAP_DIS_LSB = 8;

  // Port status register fields
  localparam int unsigned STAT_PWR_LSB = 0;
  localparam int unsigned STAT_PIN2_LOW_BIT = 2;
  localparam int unsigned STAT_OC_LSB = 3;
  localparam int unsigned STAT_DETECT_BIT = 5;

  // Interrupt status bits
  localparam int unsigned IRQ_OC_LSB = 0;
  localparam int unsigned IRQ_VBUS_RISE_BIT = 2;
  localparam int unsigned IRQ_VBUS_FALL_BIT = 3;
  localparam int unsigned IRQ_STRAP_BIT = 4;
  localparam int unsigned IRQ_WIDTH = 5;

  // Values after reset
  localparam logic [NUM_CTL_PINS-1:0] PWR_REQ_RST = 2'h0;
  localparam logic [IRQ_WIDTH-1:0] IRQ_EN_RST = 5'h00;

  // Cycle counts
  localparam int unsigned RENEG_NS = 1000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned RENEG_CYCLES = RENEG_NS / CLK_PERIOD_NS;
  localparam int unsigned OC_FILTER_CYCLES = 4;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } hpp_bus_req_t;

  typedef struct packed {
    logic [NUM_PORTS-1:0] plus_line;
    logic [NUM_PORTS-1:0] minus_line;
  } hpp_strap_t;

endpackage

// ---- core/hpp_port_power_ctl.sv ----
/*
  Port power enable and overcurrent sense for ports 1 and 2, port disable
  straps for ports 1 to 4, upstream bus-power detect with renegotiation
  pulse, and the shared general purpose pin sixteen.
  Assumes every pin input is asynchronous to core_clk, that rst is the
  power-on reset, and that the testbench resolves the two-way pins.
*/
// Strobed register access and the placing of the registers are this design's own decisions.
// Contract
// - Latch straps at power-on and reset release
// - Port disabled from plus and minus straps
// - Drive control pin high powers the port
// - Control pin low when input means overcurrent (here sensed only while the port is powered and the pin driven)
// - Sample bus-power detect as upstream power
// - Bus-power toggle renegotiates without chip reset
// - Detect pin doubles as general io sixteen
// - External reset holds device in reset mode
`timescale 1ns/100ps
module hpp_port_power_ctl #(
  parameter int unsigned OC_FILTER = hpp_pkg::OC_FILTER_CYCLES,
  parameter int unsigned RENEG_LEN = hpp_pkg::RENEG_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ext_reset_n,
  input wire hpp_pkg::hpp_strap_t strap_in,
  input wire logic [1:0] ctl_pin_in,
  output logic [1:0] ctl_pin_out,
  output logic [1:0] ctl_pin_oe,
  input wire logic bus_power_pin_in,
  output logic bus_power_pin_out,
  output logic bus_power_pin_oe,
  input wire hpp_pkg::hpp_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  output logic [3:0] port_disabled,
  output logic upstream_power_present,
  output logic upstream_reneg,
  output logic device_in_reset,
  output logic irq
);

  // Counter widths and end values sized from the parameters
  localparam int unsigned OC_W = $clog2(OC_FILTER + 1);
  localparam int unsigned RENEG_W = $clog2(RENEG_LEN + 1);
  localparam logic [OC_W-1:0] OC_TOP = OC_FILTER[OC_W-1:0];
  localparam logic [RENEG_W-1:0] RENEG_TOP = RENEG_LEN[RENEG_W-1:0];

  // Two-flop synchronisers for every pin input
  logic [1:0] ctl_meta_r, ctl_sync_r;
  logic vbus_meta_r, vbus_sync_r;
  logic rstn_meta_r, rstn_sync_r;
  hpp_pkg::hpp_strap_t strap_meta_r, strap_sync_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctl_meta_r <= 2'h3;
      ctl_sync_r <= 2'h3;
      vbus_meta_r <= 1'h0;
      vbus_sync_r <= 1'h0;
      rstn_meta_r <= 1'h0;
      rstn_sync_r <= 1'h0;
      strap_meta_r <= '0;
      strap_sync_r <= '0;
    end else begin
      ctl_meta_r <= ctl_pin_in;
      ctl_sync_r <= ctl_meta_r;
      vbus_meta_r <= bus_power_pin_in;
      vbus_sync_r <= vbus_meta_r;
      rstn_meta_r <= ext_reset_n;
      rstn_sync_r <= rstn_meta_r;
      strap_meta_r <= strap_in;
      strap_sync_r <= strap_meta_r;
    end
  end

  // External reset: low holds the block in reset mode
  logic rstn_prev_r;
  logic por_pend_r;
  logic ext_rst_act;
  logic strap_capture;
  assign ext_rst_act = ~rstn_sync_r;
  // Capture once after power-on, and on every release of the external reset
  assign strap_capture = (rstn_sync_r & ~rstn_prev_r) | (por_pend_r & rstn_sync_r);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rstn_prev_r <= 1'h0;
      por_pend_r <= 1'h1;
    end else begin
      rstn_prev_r <= rstn_sync_r;
      if (strap_capture) begin
        por_pend_r <= 1'h0;
      end
    end
  end

  // Strap latch holds until the next capture event
  hpp_pkg::hpp_strap_t strap_r;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      strap_r <= '0;
    end else if (strap_capture) begin
      strap_r <= strap_sync_r;
    end
  end

  // A port is disabled only when both of its straps are pulled high
  logic [3:0] port_dis_nxt;
  assign port_dis_nxt = strap_r.plus_line & strap_r.minus_line;

  // Software control state
  logic [1:0] pwr_req_r;
  logic gpio_mode_r;
  logic gpio_out_r;
  logic gpio_oe_r;
  logic [hpp_pkg::IRQ_WIDTH-1:0] irq_en_r;
  logic [hpp_pkg::IRQ_WIDTH-1:0] irq_stat_r;
  logic [1:0] oc_latched_r;

  // One write decode shared by every writable register
  function automatic logic wr_hit(input hpp_pkg::hpp_bus_req_t req, input logic [7:0] offset);
    return req.wr && (req.addr == offset);
  endfunction

  logic wr_ctrl, wr_clr, wr_en, wr_gpio;
  assign wr_ctrl = wr_hit(bus_req, hpp_pkg::REG_CTRL);
  assign wr_clr = wr_hit(bus_req, hpp_pkg::REG_IRQ_CLR);
  assign wr_en = wr_hit(bus_req, hpp_pkg::REG_IRQ_EN);
  assign wr_gpio = wr_hit(bus_req, hpp_pkg::REG_GPIO);

  always_ff @(posedge core_clk) begin
    if (rst || ext_rst_act) begin
      pwr_req_r <= hpp_pkg::PWR_REQ_RST;
      gpio_mode_r <= 1'h0;
    end else if (wr_ctrl) begin
      pwr_req_r <= bus_req.wdata[hpp_pkg::CTRL_PWR_REQ_LSB +: 2];
      gpio_mode_r <= bus_req.wdata[hpp_pkg::CTRL_GPIO_MODE_BIT];
    end
  end

  // General io sixteen output side, used only in gpio mode
  always_ff @(posedge core_clk) begin
    if (rst || ext_rst_act) begin
      gpio_out_r <= 1'h0;
      gpio_oe_r <= 1'h0;
    end else if (wr_gpio) begin
      gpio_out_r <= bus_req.wdata[hpp_pkg::GPIO_OUT_BIT];
      gpio_oe_r <= bus_req.wdata[hpp_pkg::GPIO_OE_BIT];
    end
  end

  // Interrupt enables; cleared by the external reset like the other controls
  always_ff @(posedge core_clk) begin
    if (rst || ext_rst_act) begin
      irq_en_r <= hpp_pkg::IRQ_EN_RST;
    end else if (wr_en) begin
      irq_en_r <= bus_req.wdata[hpp_pkg::IRQ_WIDTH-1:0];
    end
  end

  // Overcurrent sense: only while the port is powered and the switch
  // pulls the pin low against our weak drive. A short filter
  // rejects glitches; a real fault holds the pin low for many cycles.
  logic [1:0] pwr_on;
  logic [1:0] oc_event;
  logic [OC_W-1:0] oc_cnt_r [2];

  for (genvar p = 0; p < 2; p++) begin : g_oc
    always_ff @(posedge core_clk) begin
      if (rst || ext_rst_act || !pwr_on[p]) begin
        oc_cnt_r[p] <= '0;
      end else if (!ctl_sync_r[p]) begin
        if (oc_cnt_r[p] != OC_TOP) begin
          oc_cnt_r[p] <= oc_cnt_r[p] + 1'h1;
        end
      end else begin
        oc_cnt_r[p] <= '0;
      end
    end
    assign oc_event[p] = pwr_on[p] && !ctl_sync_r[p] &&
      (oc_cnt_r[p] == OC_TOP - 1'h1);
  end

  // Latched overcurrent keeps the port off until software clears it
  always_ff @(posedge core_clk) begin
    if (rst || ext_rst_act) begin
      oc_latched_r <= 2'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (oc_event[p]) begin
          oc_latched_r[p] <= 1'h1;
        end else if (wr_ctrl && bus_req.wdata[hpp_pkg::CTRL_OC_CLR_LSB + p]) begin
          oc_latched_r[p] <= 1'h0;
        end
      end
    end
  end

  assign pwr_on = pwr_req_r & ~oc_latched_r & ~port_dis_nxt[1:0];

  // Control pins: driven high to power the port, released to cut it
  always_ff @(posedge core_clk) begin
    if (rst || ext_rst_act) begin
      ctl_pin_out <= 2'h0;
      ctl_pin_oe <= 2'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        ctl_pin_out[p] <= pwr_on[p] && !oc_event[p];
        // Release the pin when unpowered so the monitor can be sensed
        ctl_pin_oe[p] <= pwr_on[p] && !oc_event[p];
      end
    end
  end

  // Bus-power detect: sampled level, rising edge triggers renegotiation
  logic vbus_prev_r;
  logic vbus_rise, vbus_fall;
  logic [RENEG_W-1:0] reneg_cnt_r;
  assign vbus_rise = !gpio_mode_r && vbus_sync_r && !vbus_prev_r;
  assign vbus_fall = !gpio_mode_r && !vbus_sync_r && vbus_prev_r;

  // Previous detect level; resets low like the synchroniser, so no false edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      vbus_prev_r <= 1'h0;
    end else begin
      vbus_prev_r <= vbus_sync_r;
    end
  end

  // Renegotiation stays local: no chip reset, only the upstream link
  always_ff @(posedge core_clk) begin
    if (rst || ext_rst_act) begin
      reneg_cnt_r <= '0;
    end else if (vbus_rise) begin
      reneg_cnt_r <= RENEG_TOP;
    end else if (reneg_cnt_r != '0) begin
      reneg_cnt_r <= reneg_cnt_r - 1'h1;
    end
  end

  // Sticky interrupt status; a new event wins over a same-cycle clear
  logic [hpp_pkg::IRQ_WIDTH-1:0] irq_set;
  assign irq_set = {strap_capture, vbus_fall, vbus_rise, oc_event};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~(wr_clr ? bus_req.wdata[hpp_pkg::IRQ_WIDTH-1:0] : '0)) | irq_set;
    end
  end

  // Port disable status follows the latched straps
  always_ff @(posedge core_clk) begin
    if (rst) begin
      port_disabled <= 4'h0;
    end else begin
      port_disabled <= port_dis_nxt;
    end
  end

  // Upstream presence and renegotiation; the pin means nothing in gpio mode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      upstream_power_present <= 1'h0;
      upstream_reneg <= 1'h0;
    end else begin
      upstream_power_present <= !gpio_mode_r && vbus_sync_r;
      upstream_reneg <= (reneg_cnt_r != '0) || vbus_rise;
    end
  end

  // Reset mode flag starts high, so nothing looks ready before the sync
  always_ff @(posedge core_clk) begin
    if (rst) begin
      device_in_reset <= 1'h1;
    end else begin
      device_in_reset <= ext_rst_act;
    end
  end

  // Level interrupt while any enabled sticky bit is set
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'h0;
    end else begin
      irq <= |(irq_stat_r & irq_en_r);
    end
  end

  // General io sixteen drive, released whenever the pin is not in gpio mode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_power_pin_out <= 1'h0;
      bus_power_pin_oe <= 1'h0;
    end else begin
      bus_power_pin_out <= gpio_mode_r && gpio_out_r;
      bus_power_pin_oe <= gpio_mode_r && gpio_oe_r;
    end
  end

  // Read word built from the field positions, so the map lives in one place
  logic [31:0] rdata_nxt;
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (bus_req.addr)
      hpp_pkg::REG_CTRL: begin
        rdata_nxt[hpp_pkg::CTRL_PWR_REQ_LSB +: 2] = pwr_req_r;
        rdata_nxt[hpp_pkg::CTRL_GPIO_MODE_BIT] = gpio_mode_r;
        rdata_nxt[hpp_pkg::CTRL_OC_CLR_LSB +: 2] = oc_latched_r;
      end
      hpp_pkg::REG_STRAP: begin
        rdata_nxt[hpp_pkg::STRAP_PLUS_LSB +: 4] = strap_r.plus_line;
        rdata_nxt[hpp_pkg::STRAP_MINUS_LSB +: 4] = strap_r.minus_line;
        rdata_nxt[hpp_pkg::STRAP_DIS_LSB +: 4] = port_dis_nxt;
      end
      hpp_pkg::REG_PORT_STAT: begin
        rdata_nxt[hpp_pkg::STAT_PWR_LSB +: 2] = pwr_on;
        rdata_nxt[hpp_pkg::STAT_PIN2_LOW_BIT] = ~ctl_sync_r[1];
        rdata_nxt[hpp_pkg::STAT_OC_LSB +: 2] = oc_latched_r;
        rdata_nxt[hpp_pkg::STAT_DETECT_BIT] = vbus_sync_r;
      end
      hpp_pkg::REG_IRQ_STAT: begin
        rdata_nxt[hpp_pkg::IRQ_WIDTH-1:0] = irq_stat_r;
      end
      hpp_pkg::REG_IRQ_EN: begin
        rdata_nxt[hpp_pkg::IRQ_WIDTH-1:0] = irq_en_r;
      end
      hpp_pkg::REG_GPIO: begin
        rdata_nxt[hpp_pkg::GPIO_OUT_BIT] = gpio_out_r;
        rdata_nxt[hpp_pkg::GPIO_OE_BIT] = gpio_oe_r;
        rdata_nxt[hpp_pkg::GPIO_IN_BIT] = vbus_sync_r;
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_rdata <= 32'h0000_0000;
    end else if (bus_req.rd) begin
      bus_rdata <= rdata_nxt;
    end else begin
      bus_rdata <= 32'h0000_0000;
    end
  end

endmodule

// ---- verif/hpp_pwr_sva.sv ----
/*
  Checker for the port power block.
  Sees only top ports; bound from the bench.
*/
`timescale 1ns/100ps
module hpp_pwr_sva #(
  parameter int unsigned OC_FILTER = 2,
  parameter int unsigned RENEG_LEN = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ext_reset_n,
  input wire logic [1:0] ctl_pin_in,
  input wire logic [1:0] ctl_pin_out,
  input wire logic [1:0] ctl_pin_oe,
  input wire logic bus_power_pin_in,
  input wire logic bus_power_pin_oe,
  input wire hpp_pkg::hpp_bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire logic upstream_power_present,
  input wire logic upstream_reneg,
  input wire logic device_in_reset
);
  // One domain; pulse check assumes RENEG_LEN of 7 or more
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  drive_high_a: assert property ((ctl_pin_oe & ~ctl_pin_out) == 2'h0)
    else $error("control pin driven low");
  oc_drop_a: assert property ($fell(ctl_pin_in[0]) && ctl_pin_oe[0] |-> ##[1:9] !ctl_pin_oe[0])
    else $error("power kept after overcurrent");
  reneg_cause_a: assert property ($rose(upstream_reneg) |-> $past(bus_power_pin_in, 2) && $past(bus_power_pin_in))
    else $error("renegotiation without detect edge");
  reneg_len_a: assert property ($rose(upstream_reneg) |-> upstream_reneg [*8])
    else $error("renegotiation too short");
  gpio_own_a: assert property (bus_power_pin_oe |-> !upstream_power_present)
    else $error("power seen while pin is gpio");
  reset_mode_a: assert property ($fell(ext_reset_n) |-> ##[1:5] device_in_reset)
    else $error("reset mode not entered");
  reset_pins_a: assert property (device_in_reset && $past(device_in_reset) |-> ctl_pin_oe == 2'h0)
    else $error("pins driven in reset");
  rdata_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule

// ---- verif/hpp_switch_model.sv ----
/*
  Power switch and current monitor model for the shared pins.
  Released control pins idle high through pull-ups; the detect pin follows the divider unless the device drives it.
*/
`timescale 1ns/100ps
module hpp_switch_model (
  input wire logic [1:0] ctl_pin_out,
  input wire logic [1:0] ctl_pin_oe,
  input wire logic [1:0] oc_req,
  input wire logic bus_power_pin_out,
  input wire logic bus_power_pin_oe,
  input wire logic vbus_lvl,
  output logic [1:0] ctl_pin_in,
  output logic bus_power_pin_in
);
  // Open-drain monitor beats the device drive
  assign ctl_pin_in = ~oc_req & ((ctl_pin_oe & ctl_pin_out) | ~ctl_pin_oe);
  // Device drive wins in gpio use, else divider level
  assign bus_power_pin_in = bus_power_pin_oe ? bus_power_pin_out : vbus_lvl;
endmodule

// ---- verif/test_hpp_port_power_ctl.sv ----
/*
  Bench: register tasks, pin stimulus, verdict.
  Assumes the switch model resolves the pins.
*/
`timescale 1ns/100ps
module test_hpp_port_power_ctl;
  logic core_clk, rst, ext_reset_n, vbus_lvl, bus_power_pin_in, bus_power_pin_out, bus_power_pin_oe;
  logic upstream_power_present, upstream_reneg, device_in_reset, irq;
  logic [1:0] ctl_pin_in, ctl_pin_out, ctl_pin_oe, oc_req;
  logic [3:0] port_disabled;
  logic [31:0] bus_rdata;
  hpp_pkg::hpp_strap_t strap_in;
  hpp_pkg::hpp_bus_req_t bus_req;
  int n_mismatch = 0, cmp_count = 0, n;
  initial begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end
  hpp_port_power_ctl #(.OC_FILTER(2), .RENEG_LEN(8)) u_hpp_port_power_ctl (
    .core_clk(core_clk), .rst(rst), .ext_reset_n(ext_reset_n), .strap_in(strap_in),
    .ctl_pin_in(ctl_pin_in), .ctl_pin_out(ctl_pin_out), .ctl_pin_oe(ctl_pin_oe),
    .bus_power_pin_in(bus_power_pin_in), .bus_power_pin_out(bus_power_pin_out),
    .bus_power_pin_oe(bus_power_pin_oe), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .port_disabled(port_disabled), .upstream_power_present(upstream_power_present),
    .upstream_reneg(upstream_reneg), .device_in_reset(device_in_reset), .irq(irq));
  hpp_switch_model u_hpp_switch_model (
    .ctl_pin_out(ctl_pin_out), .ctl_pin_oe(ctl_pin_oe), .oc_req(oc_req), .vbus_lvl(vbus_lvl),
    .bus_power_pin_out(bus_power_pin_out), .bus_power_pin_oe(bus_power_pin_oe),
    .ctl_pin_in(ctl_pin_in), .bus_power_pin_in(bus_power_pin_in));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Entered right after an edge; strobe lasts one cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge core_clk);
    bus_req <= '0;
    @(posedge core_clk);
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
    @(posedge core_clk);
    bus_req <= '0;
    #1 chk(what, bus_rdata & m, exp);
    @(posedge core_clk);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge core_clk);
    n_mismatch++;
    results();
  end
  initial begin
    rst = 1; ext_reset_n = 1; oc_req = 0; vbus_lvl = 0; bus_req = '0;
    strap_in = '{plus_line: 4'hA, minus_line: 4'hE};
    repeat (16) @(posedge core_clk);
    rst <= 0;
    repeat (8) @(posedge core_clk);
    chk("disabled", 32'(port_disabled), 32'hA);
    rd("straps", hpp_pkg::REG_STRAP, 32'hFFF, 32'hAEA);
    chk("irq masked", 32'(irq), 32'h0);
    // Port 2 is strapped off, so only port 1 powers
    strap_in <= '0;
    wr(hpp_pkg::REG_CTRL, 32'h3);
    @(posedge core_clk);
    chk("strap hold", 32'(port_disabled), 32'hA);
    chk("port1 only", 32'(ctl_pin_oe), 32'h1);
    ext_reset_n <= 0;
    repeat (6) @(posedge core_clk);
    chk("in reset", 32'(device_in_reset), 32'h1);
    chk("released", 32'(ctl_pin_oe), 32'h0);
    wr(hpp_pkg::REG_CTRL, 32'h3);
    ext_reset_n <= 1;
    repeat (6) @(posedge core_clk);
    chk("recaptured", 32'(port_disabled), 32'h0);
    chk("write ignored", 32'(ctl_pin_oe), 32'h0);
    wr(hpp_pkg::REG_CTRL, 32'h3);
    @(posedge core_clk);
    chk("drive", 32'({ctl_pin_oe, ctl_pin_out}), 32'hF);
    rd("powered", hpp_pkg::REG_PORT_STAT, 32'h3, 32'h3);
    // Overcurrent on port 1 only
    wr(hpp_pkg::REG_IRQ_EN, 32'h1);
    oc_req <= 2'h1;
    n = 0;
    while (ctl_pin_oe[0] === 1'h1 && n < 20) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk("oc drop", 32'(ctl_pin_oe), 32'h2);
    repeat (2) @(posedge core_clk);
    chk("irq up", 32'(irq), 32'h1);
    rd("oc status", hpp_pkg::REG_IRQ_STAT, 32'h3, 32'h1);
    oc_req <= 2'h0;
    wr(hpp_pkg::REG_IRQ_CLR, 32'h1);
    @(posedge core_clk);
    chk("irq clear", 32'(irq), 32'h0);
    rd("oc latch", hpp_pkg::REG_PORT_STAT, 32'h18, 32'h08);
    wr(hpp_pkg::REG_CTRL, 32'h103);
    @(posedge core_clk);
    chk("repower", 32'(ctl_pin_oe), 32'h3);
    // Toggle detect: renegotiate, no chip reset
    vbus_lvl <= 1;
    n = 0;
    while (upstream_reneg !== 1'h1 && n < 20) begin
      @(posedge core_clk);
      #1 n++;
    end
    n = 0;
    while (upstream_reneg === 1'h1 && n < 40) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk("reneg len", 32'(n), 32'h9);
    chk("no chip reset", 32'(device_in_reset), 32'h0);
    chk("power seen", 32'(upstream_power_present), 32'h1);
    rd("rise flag", hpp_pkg::REG_IRQ_STAT, 32'h1C, 32'h14);
    // Detect falls: flagged, and presence drops
    vbus_lvl <= 0;
    repeat (4) @(posedge core_clk);
    chk("power gone", 32'(upstream_power_present), 32'h0);
    rd("fall flag", hpp_pkg::REG_IRQ_STAT, 32'h8, 32'h8);
    // Detect pin as general io, driven high over a low divider
    wr(hpp_pkg::REG_CTRL, 32'h13);
    wr(hpp_pkg::REG_GPIO, 32'h3);
    repeat (2) @(posedge core_clk);
    chk("gpio drive", 32'({bus_power_pin_oe, bus_power_pin_out}), 32'h3);
    chk("gpio mode", 32'(upstream_power_present), 32'h0);
    rd("gpio in", hpp_pkg::REG_GPIO, 32'h4, 32'h4);
    rd("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
    results();
  end
endmodule
bind hpp_port_power_ctl hpp_pwr_sva #(.OC_FILTER(OC_FILTER), .RENEG_LEN(RENEG_LEN)) u_hpp_pwr_sva (
  .core_clk(core_clk), .rst(rst), .ext_reset_n(ext_reset_n), .ctl_pin_in(ctl_pin_in),
  .ctl_pin_out(ctl_pin_out), .ctl_pin_oe(ctl_pin_oe), .bus_power_pin_in(bus_power_pin_in),
  .bus_power_pin_oe(bus_power_pin_oe), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .upstream_power_present(upstream_power_present), .upstream_reneg(upstream_reneg),
  .device_in_reset(device_in_reset));
